// *** design/psc_pkg.sv ***
// Constants and types shared by the phase sweep command control block.
package psc_pkg;
   // Command codes on the command port.
   typedef enum logic [3:0] {
      PSC_CMD_NONE = 4'h0,
      PSC_CMD_SINGLE = 4'h1,
      PSC_CMD_SS_ENABLE = 4'h2,
      PSC_CMD_START_STATE = 4'h3,
      PSC_CMD_STOP_STATE = 4'h4,
      PSC_CMD_PAUSE = 4'h5,
      PSC_CMD_CONTINUE = 4'h6,
      PSC_CMD_PIE = 4'h7,
      PSC_CMD_AMP_MOD = 4'h8,
      PSC_CMD_DUTY = 4'h9,
      PSC_CMD_DUTY_FIXED = 4'hA,
      PSC_CMD_SAVE = 4'hB,
      PSC_CMD_RESTORE = 4'hC,
      PSC_CMD_PRESET = 4'hD,
      PSC_CMD_OUT = 4'hE,
      PSC_CMD_RANGE = 4'hF
   } psc_cmd_type;

   // Sweep states.
   typedef enum logic [2:0] {
      PSC_ST_IDLE = 3'b000,
      PSC_ST_RUN = 3'b001,
      PSC_ST_AT_START = 3'b010,
      PSC_ST_AT_STOP = 3'b011
   } psc_state_type;

   // Duty cycle in tenths of a percent.
   localparam logic [9:0] PSC_DUTY_MIN = 10'h032;
   localparam logic [9:0] PSC_DUTY_MAX = 10'h3B6;
   localparam logic [9:0] PSC_DUTY_HALF = 10'h1F4;
   localparam logic [3:0] PSC_SLOT_MAX = 4'h9;
   localparam int PSC_SLOTS = 10;
   // Saved settings word layout.
   localparam int PSC_SET_W = 15;
   localparam int PSC_F_DUTY = 0;
   localparam int PSC_F_AMP_MOD = 10;
   localparam int PSC_F_OUT = 11;
   localparam int PSC_F_RANGE = 12;
   localparam int PSC_F_SS_ENABLE = 13;
   localparam int PSC_F_PIE = 14;
   // Preset values: duty 50 percent, mod off, output off, auto range, inputs enabled.
   localparam logic [14:0] PSC_SET_PRESET = 15'h61F4;
   // Register read addresses.
   localparam logic [7:0] PSC_ADDR_STATUS = 8'h00;
   localparam logic [7:0] PSC_ADDR_SETTINGS = 8'h04;
   localparam logic [7:0] PSC_ADDR_ERROR = 8'h08;
endpackage : psc_pkg

// *** design/psc_setting_mem.sv ***
// Ten-slot store for saved setting words.
`timescale 1ns/1ps
`default_nettype none
module psc_setting_mem #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 10
) (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [3:0] waddr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   input wire logic [3:0] raddr_i,
   output logic [WIDTH-1:0] rdata_o
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
   end

   assign rdata_o = mem_q[raddr_i];
endmodule // psc_setting_mem
`default_nettype wire

// *** design/psc_sweep_ctrl.sv ***
// Sweep state machine with start, stop, pause and continue control.
`timescale 1ns/1ps
`default_nettype none
module psc_sweep_ctrl (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic single_go_i,
   input wire logic goto_start_i,
   input wire logic goto_stop_i,
   input wire logic pause_cmd_i,
   input wire logic continue_cmd_i,
   input wire logic pause_pin_act_i,
   input wire logic sweep_done_i,
   output psc_pkg::psc_state_type state_o,
   output logic cmd_pause_o,
   output logic paused_o,
   output logic sweep_start_o
);
   psc_pkg::psc_state_type state_q;
   psc_pkg::psc_state_type state_d;
   logic cmd_pause_q;
   logic cmd_pause_d;
   logic running;

   assign running = (state_q == psc_pkg::PSC_ST_RUN);

   always_comb begin
      state_d = state_q;
      cmd_pause_d = cmd_pause_q;
      case (state_q)
         psc_pkg::PSC_ST_RUN: begin
            if (pause_cmd_i && !pause_pin_act_i && !cmd_pause_q) begin
               cmd_pause_d = 1'b1;
            end
            if (continue_cmd_i && cmd_pause_q && !pause_pin_act_i) begin
               cmd_pause_d = 1'b0;
            end
            if (sweep_done_i) begin
               state_d = psc_pkg::PSC_ST_IDLE;
            end
         end
         default: begin
            if (single_go_i) begin
               state_d = psc_pkg::PSC_ST_RUN;
               cmd_pause_d = 1'b0;
            end
         end
      endcase
      if (goto_start_i) begin
         state_d = psc_pkg::PSC_ST_AT_START;
         cmd_pause_d = 1'b0;
      end
      if (goto_stop_i) begin
         state_d = psc_pkg::PSC_ST_AT_STOP;
         cmd_pause_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state_q <= psc_pkg::PSC_ST_IDLE;
         cmd_pause_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cmd_pause_q <= cmd_pause_d;
      end
   end

   assign state_o = state_q;
   assign cmd_pause_o = cmd_pause_q;
   assign paused_o = running && (cmd_pause_q || pause_pin_act_i);
   assign sweep_start_o = (state_d == psc_pkg::PSC_ST_RUN) && !running;
endmodule // psc_sweep_ctrl
`default_nettype wire

// *** design/psc_top.sv ***
// Command interpreter for the phase sweep option.
`timescale 1ns/1ps
`default_nettype none
module psc_top (
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Command port: one-cycle strobe with code and parameter.
   input wire logic cmd_valid_i,
   input wire logic [3:0] cmd_code_i,
   input wire logic [9:0] cmd_param_i,
   // Remote or local operation.
   input wire logic remote_i,
   // Rear-panel inputs, synchronous; pause input active low.
   input wire logic single_start_input_i,
   input wire logic pause_input_b_i,
   input wire logic sweep_done_i,
   // Register read port.
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Setting and status outputs.
   output logic [2:0] sweep_state_o,
   output logic sweep_start_o,
   output logic sweep_paused_o,
   output logic cmd_error_o,
   output logic [9:0] duty_o,
   output logic amp_mod_o,
   output logic waveform_out_o,
   output logic fixed_range_o,
   output logic single_start_input_enable_o,
   output logic pause_input_enable_o
);
   logic [psc_pkg::PSC_SET_W-1:0] set_q;
   logic [psc_pkg::PSC_SET_W-1:0] set_d;
   logic [psc_pkg::PSC_SET_W-1:0] recall_data;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic err_q;
   logic err_d;
   logic single_in_q;
   logic [2:0] state_q;
   logic start_q;
   logic paused_q;
   psc_pkg::psc_state_type state_w;
   logic cmd_pause_w;
   logic paused_w;
   logic start_w;

   wire is_cmd = cmd_valid_i;
   wire [3:0] code = cmd_code_i;
   wire bit_ok = (cmd_param_i <= 10'h001);
   wire slot_ok = (cmd_param_i <= {6'h00, psc_pkg::PSC_SLOT_MAX});
   wire duty_ok = (cmd_param_i >= psc_pkg::PSC_DUTY_MIN) &&
      (cmd_param_i <= psc_pkg::PSC_DUTY_MAX);
   wire c_single = is_cmd && (code == psc_pkg::PSC_CMD_SINGLE);
   wire c_ss_en = is_cmd && (code == psc_pkg::PSC_CMD_SS_ENABLE);
   wire c_start = is_cmd && (code == psc_pkg::PSC_CMD_START_STATE);
   wire c_stop = is_cmd && (code == psc_pkg::PSC_CMD_STOP_STATE);
   wire c_pause = is_cmd && (code == psc_pkg::PSC_CMD_PAUSE);
   wire c_cont = is_cmd && (code == psc_pkg::PSC_CMD_CONTINUE);
   wire c_pie = is_cmd && (code == psc_pkg::PSC_CMD_PIE);
   wire c_amp = is_cmd && (code == psc_pkg::PSC_CMD_AMP_MOD);
   wire c_duty = is_cmd && (code == psc_pkg::PSC_CMD_DUTY);
   wire c_half = is_cmd && (code == psc_pkg::PSC_CMD_DUTY_FIXED);
   wire c_save = is_cmd && (code == psc_pkg::PSC_CMD_SAVE);
   wire c_rest = is_cmd && (code == psc_pkg::PSC_CMD_RESTORE);
   wire c_pre = is_cmd && (code == psc_pkg::PSC_CMD_PRESET);
   wire c_out = is_cmd && (code == psc_pkg::PSC_CMD_OUT);
   wire c_rng = is_cmd && (code == psc_pkg::PSC_CMD_RANGE);

   // Local forces the input on; stored remote enable kept.
   wire ss_en_eff = !remote_i || set_q[psc_pkg::PSC_F_SS_ENABLE];
   // Local forces the pause input on.
   wire pie_eff = !remote_i || set_q[psc_pkg::PSC_F_PIE];
   // Enabled low pause input holds the sweep.
   wire pin_hold = pie_eff && !pause_input_b_i && !cmd_pause_w;
   // Rising edge of the enabled single-start input.
   wire pin_go = ss_en_eff && single_start_input_i && !single_in_q;
   wire go = c_single || pin_go;
   // Pause and continue commands blocked while the pin holds.
   wire pause_go = c_pause && !pin_hold;
   wire cont_go = c_cont && !pin_hold;

   wire bit_cmd = c_ss_en || c_pie || c_amp || c_out || c_rng;
   wire slot_cmd = c_save || c_rest;
   wire bad = (bit_cmd && !bit_ok) || (slot_cmd && !slot_ok) || (c_duty && !duty_ok);

   psc_sweep_ctrl u_sweep (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .single_go_i(go),
      .goto_start_i(c_start),
      .goto_stop_i(c_stop),
      .pause_cmd_i(pause_go),
      .continue_cmd_i(cont_go),
      .pause_pin_act_i(pin_hold),
      .sweep_done_i(sweep_done_i),
      .state_o(state_w),
      .cmd_pause_o(cmd_pause_w),
      .paused_o(paused_w),
      .sweep_start_o(start_w)
   );

   psc_setting_mem #(
      .WIDTH(psc_pkg::PSC_SET_W),
      .DEPTH(psc_pkg::PSC_SLOTS)
   ) u_mem (
      .clk_i(clk_i),
      .we_i(c_save && slot_ok),
      .waddr_i(cmd_param_i[3:0]),
      .wdata_i(set_q),
      .raddr_i(cmd_param_i[3:0]),
      .rdata_o(recall_data)
   );

   always_comb begin
      set_d = set_q;
      if (c_ss_en && bit_ok) begin
         set_d[psc_pkg::PSC_F_SS_ENABLE] = cmd_param_i[0];
      end
      if (c_pie && bit_ok) begin
         set_d[psc_pkg::PSC_F_PIE] = cmd_param_i[0];
      end
      if (c_amp && bit_ok) begin
         set_d[psc_pkg::PSC_F_AMP_MOD] = cmd_param_i[0];
      end
      // Duty in tenths of a percent.
      if (c_duty && duty_ok) begin
         set_d[psc_pkg::PSC_F_DUTY +: 10] = cmd_param_i;
      end
      if (c_half) begin
         set_d[psc_pkg::PSC_F_DUTY +: 10] = psc_pkg::PSC_DUTY_HALF;
      end
      if (c_out && bit_ok) begin
         set_d[psc_pkg::PSC_F_OUT] = cmd_param_i[0];
      end
      if (c_rng && bit_ok) begin
         set_d[psc_pkg::PSC_F_RANGE] = cmd_param_i[0];
      end
      if (c_rest && slot_ok) begin
         set_d = recall_data;
      end
      if (c_pre) begin
         set_d = psc_pkg::PSC_SET_PRESET;
      end
   end

   // Error flag is sticky; a new error wins over a read that clears it.
   always_comb begin
      err_d = err_q;
      if (rd_i && (addr_i == psc_pkg::PSC_ADDR_ERROR)) begin
         err_d = 1'b0;
      end
      if (is_cmd && bad) begin
         err_d = 1'b1;
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (rd_i) begin
         case (addr_i)
            psc_pkg::PSC_ADDR_STATUS: rdata_d = {26'h0, cmd_pause_w, paused_w, 1'b0, state_w};
            psc_pkg::PSC_ADDR_SETTINGS: rdata_d = {17'h0, set_q};
            psc_pkg::PSC_ADDR_ERROR: rdata_d = {31'h0, err_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         set_q <= psc_pkg::PSC_SET_PRESET;
         err_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         single_in_q <= 1'b0;
         state_q <= 3'h0;
         start_q <= 1'b0;
         paused_q <= 1'b0;
      end else begin
         set_q <= set_d;
         err_q <= err_d;
         rdata_q <= rdata_d;
         single_in_q <= single_start_input_i;
         state_q <= state_w;
         start_q <= start_w;
         paused_q <= paused_w;
      end
   end

   // Writes have no target; settings change only through commands.
   assign rdata_o = rdata_q;
   assign sweep_state_o = state_q;
   assign sweep_start_o = start_q;
   assign sweep_paused_o = paused_q;
   assign cmd_error_o = err_q;
   assign duty_o = set_q[psc_pkg::PSC_F_DUTY +: 10];
   assign amp_mod_o = set_q[psc_pkg::PSC_F_AMP_MOD];
   assign waveform_out_o = set_q[psc_pkg::PSC_F_OUT];
   assign fixed_range_o = set_q[psc_pkg::PSC_F_RANGE];
   assign single_start_input_enable_o = set_q[psc_pkg::PSC_F_SS_ENABLE];
   assign pause_input_enable_o = set_q[psc_pkg::PSC_F_PIE];
endmodule // psc_top
`default_nettype wire

// *** verif/psc_host.sv ***
// Remote controller model that issues commands on the command port.
`timescale 1ns/1ps
`default_nettype none
module psc_host (
   input wire logic clk_i,
   output logic cmd_valid_o,
   output logic [3:0] cmd_code_o,
   output logic [9:0] cmd_param_o
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_code_o = 4'h0;
      cmd_param_o = 10'h000;
   end
   task automatic send(input logic [3:0] c, input logic [9:0] p);
      @(posedge clk_i);
      cmd_valid_o <= 1'b1;
      cmd_code_o <= c;
      cmd_param_o <= p;
      @(posedge clk_i);
      cmd_valid_o <= 1'b0;
      // Idle fields are scrambled so a stale code is never taken for a live one.
      cmd_code_o <= ~c;
      cmd_param_o <= ~p;
   endtask
endmodule // psc_host
`default_nettype wire

// *** verif/psc_top_sva.sv ***
// Port-level checker for the phase sweep command block.
`timescale 1ns/1ps
`default_nettype none
module psc_top_sva (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic cmd_valid_i,
   input wire logic [3:0] cmd_code_i,
   input wire logic [9:0] cmd_param_i,
   input wire logic sweep_done_i,
   input wire logic [7:0] addr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic [2:0] sweep_state_o,
   input wire logic sweep_start_o,
   input wire logic sweep_paused_o,
   input wire logic cmd_error_o,
   input wire logic [9:0] duty_o,
   input wire logic amp_mod_o,
   input wire logic waveform_out_o,
   input wire logic fixed_range_o,
   input wire logic pause_input_enable_o,
   input wire logic single_start_input_enable_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   function automatic logic cmd_is(input logic [3:0] c);
      return cmd_valid_i && cmd_code_i == c;
   endfunction
   AST_RST: assert property (disable iff (1'b0) !rst_b_i |=> duty_o == 10'h1F4 &&
      pause_input_enable_o && !cmd_error_o && sweep_state_o == 3'h0)
      else $error("reset values wrong");
   AST_DUTY: assert property (cmd_is(psc_pkg::PSC_CMD_DUTY) && cmd_param_i >= 10'h032
      && cmd_param_i <= 10'h3B6 |=> duty_o == $past(cmd_param_i)) else $error("duty not set");
   AST_DUTY_BAD: assert property (cmd_is(psc_pkg::PSC_CMD_DUTY) && cmd_param_i > 10'h3B6
      |=> $stable(duty_o) && cmd_error_o) else $error("bad duty taken");
   AST_FIXED: assert property (cmd_is(psc_pkg::PSC_CMD_DUTY_FIXED) |=> duty_o == 10'h1F4)
      else $error("fixed duty wrong");
   AST_OUT: assert property (cmd_is(psc_pkg::PSC_CMD_OUT) && cmd_param_i < 10'h002
      |=> $past(cmd_param_i) == {9'h000, waveform_out_o}) else $error("output switch wrong");
   AST_AMP_MOD: assert property (cmd_is(psc_pkg::PSC_CMD_AMP_MOD) && cmd_param_i < 10'h002
      |=> $past(cmd_param_i) == {9'h000, amp_mod_o}) else $error("modulation wrong");
   AST_RANGE: assert property (cmd_is(psc_pkg::PSC_CMD_RANGE) && cmd_param_i < 10'h002
      |=> $past(cmd_param_i) == {9'h000, fixed_range_o}) else $error("range mode wrong");
   AST_PRESET: assert property (cmd_is(psc_pkg::PSC_CMD_PRESET) |=> duty_o == 10'h1F4
      && !amp_mod_o && !waveform_out_o && !fixed_range_o && pause_input_enable_o
      && single_start_input_enable_o)
      else $error("preset wrong");
   AST_GO_START: assert property (cmd_is(psc_pkg::PSC_CMD_START_STATE)
      |-> ##2 sweep_state_o == 3'h2) else $error("start state missed");
   AST_GO_STOP: assert property (cmd_is(psc_pkg::PSC_CMD_STOP_STATE)
      |-> ##2 sweep_state_o == 3'h3) else $error("stop state missed");
   AST_SINGLE: assert property (cmd_is(psc_pkg::PSC_CMD_SINGLE) && !sweep_done_i
      && !sweep_paused_o |-> ##2 sweep_state_o == 3'h1) else $error("single sweep missed");
   AST_START: assert property ($rose(sweep_state_o == 3'h1) |-> $past(sweep_start_o))
      else $error("sweep start pulse missing");
   AST_START_RUN: assert property (sweep_start_o |=> sweep_state_o == 3'h1)
      else $error("start pulse without run state");
   AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 32'h0) else $error("read data leaks");
   AST_ERR_HOLD: assert property (cmd_error_o && !(rd_i && addr_i == 8'h08)
      |=> cmd_error_o) else $error("error flag dropped");
endmodule // psc_top_sva
bind psc_top psc_top_sva chk_u (.*);
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the phase sweep command block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic remote_i = 1'b1, ss_in = 1'b0, pause_b = 1'b1, done_i = 1'b0;
   logic wr_i = 1'b0, rd_i = 1'b0, rd_seen = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic cmd_valid, start_o, paused_o, err_o, amp_o, out_o, rng_o, ss_en_o, pie_o;
   logic [3:0] cmd_code;
   logic [9:0] cmd_param, duty_o, p;
   logic [2:0] state_o;
   logic [31:0] rdata_o, rv;
   logic [31:0] exp_q[$];
   logic [14:0] set_m, saved;
   logic [13:0] bad_t [7];
   logic [3:0] cmds [4];
   int bad_count = 0, num_checks = 0, cycles = 0, k;
   always #2.5 clk_i = ~clk_i;
   psc_host host_u (.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
      .cmd_param_o(cmd_param));
   psc_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid),
      .cmd_code_i(cmd_code), .cmd_param_i(cmd_param), .remote_i(remote_i),
      .single_start_input_i(ss_in), .pause_input_b_i(pause_b), .sweep_done_i(done_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .sweep_state_o(state_o), .sweep_start_o(start_o), .sweep_paused_o(paused_o),
      .cmd_error_o(err_o), .duty_o(duty_o), .amp_mod_o(amp_o), .waveform_out_o(out_o),
      .fixed_range_o(rng_o), .single_start_input_enable_o(ss_en_o),
      .pause_input_enable_o(pie_o));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (bad_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      addr_i <= ~a;
   endtask
   task automatic sw();
      rd(8'h04, {17'h0, set_m});
      check({17'h0, pie_o, ss_en_o, rng_o, out_o, amp_o, duty_o}, {17'h0, set_m});
   endtask
   task automatic send(input logic [3:0] c, input logic [9:0] v);
      host_u.send(c, v);
   endtask
   task automatic st(input logic [2:0] e, input logic pz);
      tick(4);
      check({31'h0, paused_o}, {31'h0, pz});
      if (e != 3'h7) check({29'h0, state_o}, {29'h0, e});
   endtask
   // Pulses the sweep-done input (0) or the single-start input (1) for one cycle.
   task automatic pin(input int sel);
      @(posedge clk_i);
      if (sel == 0) done_i <= 1'b1;
      else ss_in <= 1'b1;
      @(posedge clk_i);
      done_i <= 1'b0;
      ss_in <= 1'b0;
   endtask
   // Reads finish one cycle after the strobe, so the monitor compares there.
   always @(posedge clk_i) begin
      rd_seen <= rd_i;
      if (rd_seen === 1'b1) check(rdata_o, exp_q.pop_front());
      cycles++;
      if (cycles > 20000) begin
         bad_count++;
         complete_run();
      end
   end
   initial begin
      rv = $urandom(32'hA22C386E);
      cmds = '{psc_pkg::PSC_CMD_AMP_MOD, psc_pkg::PSC_CMD_OUT, psc_pkg::PSC_CMD_RANGE,
         psc_pkg::PSC_CMD_DUTY};
      bad_t = '{{psc_pkg::PSC_CMD_DUTY, 10'h031}, {psc_pkg::PSC_CMD_DUTY, 10'h3B7},
         {psc_pkg::PSC_CMD_AMP_MOD, 10'h002}, {psc_pkg::PSC_CMD_SAVE, 10'h00A},
         {psc_pkg::PSC_CMD_RESTORE, 10'h00A}, {psc_pkg::PSC_CMD_SS_ENABLE, 10'h002},
         {psc_pkg::PSC_CMD_PIE, 10'h002}};
      set_m = psc_pkg::PSC_SET_PRESET;
      tick(2);
      rst_b_i <= 1'b1;
      sw();
      rd(8'h0C, 32'h0);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= 8'h04;
      wdata_i <= $urandom;
      @(posedge clk_i);
      wr_i <= 1'b0;
      sw();
      for (int i = 0; i < 16; i++) begin
         k = $urandom_range(3);
         p = (k == 3) ? 10'h032 + 10'($urandom_range(900)) : 10'($urandom_range(1));
         send(cmds[k], p);
         if (k == 3) set_m[9:0] = p;
         else set_m[10 + k] = p[0];
         sw();
      end
      send(psc_pkg::PSC_CMD_DUTY, 10'h3B6);
      set_m[9:0] = 10'h3B6;
      sw();
      foreach (bad_t[i]) begin
         send(bad_t[i][13:10], bad_t[i][9:0]);
         rd(8'h08, 32'h1);
         sw();
      end
      send(psc_pkg::PSC_CMD_DUTY, 10'h032);
      send(psc_pkg::PSC_CMD_DUTY_FIXED, 10'h000);
      set_m[9:0] = 10'h1F4;
      sw();
      saved = set_m;
      send(psc_pkg::PSC_CMD_SAVE, 10'h009);
      send(psc_pkg::PSC_CMD_OUT, {9'h0, ~set_m[11]});
      send(psc_pkg::PSC_CMD_DUTY, 10'h07B);
      send(psc_pkg::PSC_CMD_RESTORE, 10'h009);
      sw();
      send(psc_pkg::PSC_CMD_AMP_MOD, 10'h001);
      send(psc_pkg::PSC_CMD_PIE, 10'h000);
      send(psc_pkg::PSC_CMD_PRESET, 10'h000);
      set_m = psc_pkg::PSC_SET_PRESET;
      sw();
      send(psc_pkg::PSC_CMD_SINGLE, 10'h000);
      st(3'h1, 1'b0);
      pin(0);
      st(3'h0, 1'b0);
      send(psc_pkg::PSC_CMD_CONTINUE, 10'h000);
      rd(8'h08, 32'h0);
      send(psc_pkg::PSC_CMD_SINGLE, 10'h000);
      send(psc_pkg::PSC_CMD_PAUSE, 10'h000);
      st(3'h7, 1'b1);
      pause_b <= 1'b0;
      tick(2);
      pause_b <= 1'b1;
      st(3'h7, 1'b1);
      send(psc_pkg::PSC_CMD_CONTINUE, 10'h000);
      st(3'h7, 1'b0);
      pause_b <= 1'b0;
      st(3'h7, 1'b1);
      send(psc_pkg::PSC_CMD_CONTINUE, 10'h000);
      send(psc_pkg::PSC_CMD_PAUSE, 10'h000);
      st(3'h7, 1'b1);
      pause_b <= 1'b1;
      st(3'h7, 1'b0);
      send(psc_pkg::PSC_CMD_PIE, 10'h000);
      pause_b <= 1'b0;
      st(3'h7, 1'b0);
      remote_i <= 1'b0;
      st(3'h7, 1'b1);
      remote_i <= 1'b1;
      st(3'h7, 1'b0);
      pause_b <= 1'b1;
      send(psc_pkg::PSC_CMD_START_STATE, 10'h000);
      st(3'h2, 1'b0);
      send(psc_pkg::PSC_CMD_SINGLE, 10'h000);
      send(psc_pkg::PSC_CMD_STOP_STATE, 10'h000);
      st(3'h3, 1'b0);
      pin(0);
      send(psc_pkg::PSC_CMD_START_STATE, 10'h000);
      send(psc_pkg::PSC_CMD_SS_ENABLE, 10'h000);
      pin(1);
      st(3'h2, 1'b0);
      remote_i <= 1'b0;
      pin(1);
      st(3'h1, 1'b0);
      send(psc_pkg::PSC_CMD_STOP_STATE, 10'h000);
      remote_i <= 1'b1;
      pin(1);
      st(3'h3, 1'b0);
      send(psc_pkg::PSC_CMD_SS_ENABLE, 10'h001);
      pin(1);
      st(3'h1, 1'b0);
      tick(2);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
